// File: src/trig_params.svh
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH
// Register byte offsets
`define OFS_CTRL 4'h0
`define OFS_EXPOSE 4'h4
`define OFS_INTERVAL 4'h8
`define OFS_STATUS 4'hC
// Control field positions
`define CTRL_ARM_BIT 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
// Reset values, in clock cycles, and frame counter width
`define EXPOSE_RST 32'h0000_03E8
`define INTERVAL_RST 32'h0000_2710
`define FRAME_CNT_W 16
`endif

// File: src/trig_pkg.sv
package trig_pkg;
  typedef enum logic [1:0] {MODE_STREAM, MODE_ASYNC, MODE_LEVEL} mode_t;
  typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_EXPOSE, ST_READ, ST_GAP} state_t;
  typedef struct packed {
    mode_t mode;
    logic [31:0] expose;
    logic [31:0] interval;
  } cfg_t;
  typedef struct packed {
    logic sel;
    logic write;
    logic [3:0] addr;
  } ahb_req_t;
endpackage

// File: src/ext_trigger_exposure_ctrl.sv
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"

// How it works
// - Three trigger modes, chosen by software: streaming, single async, level-timed.
// - Sequencing uses only trigger, timers and readout handshake, nothing about readout speed.
// - Trigger pin is active low; a high-to-low change is the request.
// - Streaming: falling edge starts exposure for set time, then readout is started.
// - Streaming: frames repeat at the set interval with no further trigger.
// - Streaming: once started, triggers are ignored until software halts.
// - Async: each falling edge starts one preset exposure, then one readout.
// - Async: trigger activity during readout is ignored.
// - Async: after readout stay idle until a fresh falling edge.
// - Level-timed: expose from falling edge until the trigger rises again.
// - Level-timed: trigger changes during readout are ignored.
// - Exposure output is high for every exposure in every mode.
module ext_trigger_exposure_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic trig_n,
  input wire logic readout_done,
  output logic readout_start,
  output logic exposing
);
  import trig_pkg::*;

  // Map a written mode field, unused code falls back to async
  function automatic mode_t decode_mode(input logic [1:0] f);
    case (f)
      2'h0: decode_mode = MODE_STREAM;
      2'h2: decode_mode = MODE_LEVEL;
      default: decode_mode = MODE_ASYNC;
    endcase
  endfunction

  // Down-counter step that saturates at zero
  function automatic logic [31:0] count_down(input logic [31:0] v);
    count_down = (v == 32'h0000_0000) ? v : v - 32'h0000_0001;
  endfunction

  // Trigger synchroniser and edge history
  logic trig_s1_r;
  logic trig_s2_r;
  logic trig_d_r;

  // Bus request and software registers
  ahb_req_t req_r;
  logic arm_r;
  logic [1:0] mode_field_r;
  logic [31:0] expose_reg_r;
  logic [31:0] interval_reg_r;

  // Working copy of the configuration
  cfg_t cfg_r;

  // Sequencer state and timers
  state_t state_r;
  state_t state_nxt;
  logic [31:0] exp_cnt_r;
  logic [31:0] exp_cnt_nxt;
  logic [31:0] frm_cnt_r;
  logic [31:0] frm_cnt_nxt;

  // Registered outputs and status
  logic [`FRAME_CNT_W-1:0] frames_r;
  logic [31:0] hrdata_r;
  logic readout_start_r;
  logic exposing_r;
  logic readout_busy_r;

  // Trigger pin crosses into clk through two flops
  always_ff @(posedge clk) begin
    if (reset) begin
      trig_s1_r <= 1'b1;
      trig_s2_r <= 1'b1;
      trig_d_r <= 1'b1;
    end else begin
      trig_s1_r <= trig_n;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
    end
  end

  // Edge detection on the synchronised trigger
  wire trig_fall = trig_d_r & ~trig_s2_r;
  wire trig_rise = ~trig_d_r & trig_s2_r;

  // Bus address phase decode
  wire addr_phase = hsel & htrans[1] & hready;

  // Write strobes, one per writable register (status has none), in the data phase
  wire wr_go = req_r.sel & req_r.write;
  wire wr_ctrl = wr_go & (req_r.addr == `OFS_CTRL);
  wire wr_exp = wr_go & (req_r.addr == `OFS_EXPOSE);
  wire wr_ivl = wr_go & (req_r.addr == `OFS_INTERVAL);

  // Arm and halt requests carried by a control write
  wire new_arm = hwdata[`CTRL_ARM_BIT];
  wire arm_rise = wr_ctrl & new_arm & ~arm_r;
  wire halt = wr_ctrl & ~new_arm;

  // Latch the address phase for the following data phase
  always_ff @(posedge clk) begin
    if (reset) begin
      req_r <= '0;
    end else if (hready) begin
      req_r.sel <= addr_phase;
      req_r.write <= hwrite;
      req_r.addr <= haddr[3:0];
    end
  end

  // Software registers written in the data phase
  always_ff @(posedge clk) begin
    if (reset) begin
      arm_r <= 1'b0;
      mode_field_r <= 2'h1;
      expose_reg_r <= `EXPOSE_RST;
      interval_reg_r <= `INTERVAL_RST;
    end else begin
      if (wr_ctrl) begin
        arm_r <= new_arm;
        mode_field_r <= hwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
      end
      if (wr_exp) begin
        expose_reg_r <= hwdata;
      end
      if (wr_ivl) begin
        interval_reg_r <= hwdata;
      end
    end
  end

  // Working copy taken at arming, so later writes wait for the next arm
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r <= '{MODE_ASYNC, `EXPOSE_RST, `INTERVAL_RST};
    end else if (arm_rise) begin
      cfg_r.mode <= decode_mode(hwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
      cfg_r.expose <= expose_reg_r;
      cfg_r.interval <= interval_reg_r;
    end
  end

  // Status word fields; the spare bits read as zero
  wire [`FRAME_CNT_W-1:0] st_frames = frames_r;
  wire [8:0] st_spare = 9'h000;
  wire [2:0] st_state = state_r;
  wire [31:0] status_word = {st_frames, st_spare, readout_busy_r, exposing_r, 1'b0, st_state, arm_r};

  // Control word as read back: mode field above the arm bit
  wire [31:0] ctrl_word = {29'h0000_0000, mode_field_r, arm_r};

  // Read mux, unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[3:0])
      `OFS_CTRL: rd_mux = ctrl_word;
      `OFS_EXPOSE: rd_mux = expose_reg_r;
      `OFS_INTERVAL: rd_mux = interval_reg_r;
      `OFS_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address phase
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      hrdata_r <= rd_mux;
    end
  end

  // Timer ends; the sequencer never looks at readout rate, gain or binning
  wire exp_done = (exp_cnt_r <= 32'h0000_0001);
  wire frm_done = (frm_cnt_r <= 32'h0000_0001);

  // Mode flags from the configuration latched at arming
  wire is_stream = (cfg_r.mode == MODE_STREAM);
  wire is_level = (cfg_r.mode == MODE_LEVEL);

  // End of exposure and start of the next streaming frame
  wire end_expose = is_level ? trig_rise : exp_done;
  wire stream_frame = is_stream & frm_done;

  // Acquisition sequencer
  always_comb begin
    state_nxt = state_r;
    exp_cnt_nxt = count_down(exp_cnt_r);
    frm_cnt_nxt = count_down(frm_cnt_r);
    case (state_r)
      ST_OFF: begin
        if (arm_rise) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (trig_fall) begin
          state_nxt = ST_EXPOSE;
          exp_cnt_nxt = cfg_r.expose;
          frm_cnt_nxt = cfg_r.interval;
        end
      end
      ST_EXPOSE: begin
        if (end_expose & is_stream) begin
          state_nxt = ST_GAP;
        end else if (end_expose) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        if (readout_done) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_GAP: begin
        if (stream_frame) begin
          state_nxt = ST_EXPOSE;
          exp_cnt_nxt = cfg_r.expose;
          frm_cnt_nxt = cfg_r.interval;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (halt) begin
      state_nxt = ST_OFF;
    end
  end

  // Sequencer state and timers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_OFF;
      exp_cnt_r <= 32'h0000_0000;
      frm_cnt_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      exp_cnt_r <= exp_cnt_nxt;
      frm_cnt_r <= frm_cnt_nxt;
    end
  end

  // Readout request as the sequencer leaves exposure, unless a halt comes in the same cycle
  wire start_ro = (state_r == ST_EXPOSE) & (state_nxt != ST_EXPOSE) & ~halt;

  // Exposure strobe and readout request
  always_ff @(posedge clk) begin
    if (reset) begin
      exposing_r <= 1'b0;
      readout_start_r <= 1'b0;
    end else begin
      exposing_r <= (state_nxt == ST_EXPOSE);
      readout_start_r <= start_ro;
    end
  end

  // Readout busy flag and frame count; a new start wins over a done
  always_ff @(posedge clk) begin
    if (reset) begin
      readout_busy_r <= 1'b0;
      frames_r <= '0;
    end else if (start_ro) begin
      readout_busy_r <= 1'b1;
      frames_r <= frames_r + 1'b1;
    end else if (readout_done) begin
      readout_busy_r <= 1'b0;
    end
  end

  // Bus slave is always ready with an OKAY answer
  always_ff @(posedge clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Ports driven straight from their flops
  assign hrdata = hrdata_r;
  assign readout_start = readout_start_r;
  assign exposing = exposing_r;

endmodule
`default_nettype wire

// File: verif/trig_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"
module trig_checker
  import trig_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic trig_n,
  input wire logic readout_done,
  input wire logic readout_start,
  input wire logic exposing
);
  logic wc_r, arm_r, bz_r;
  logic [1:0] mode_r;
  // Shadow of the control word and of the readout handshake
  always_ff @(posedge clk) begin
    wc_r <= !reset && hsel && htrans[1] && hready && hwrite && haddr[3:0] == `OFS_CTRL;
    if (reset) begin
      arm_r <= 1'h0;
      mode_r <= 2'h0;
    end else if (wc_r) begin
      arm_r <= hwdata[0];
      mode_r <= hwdata[2:1];
    end
    bz_r <= !reset && (readout_start || (bz_r && !readout_done));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_reset_dark: assert property ($fell(reset) |-> !exposing && !readout_start)
    else $error("Output active after reset");
  chk_start_pulse: assert property (readout_start |=> !readout_start)
    else $error("Readout start too long");
  chk_read_after: assert property ($fell(exposing) && arm_r |-> ##[0:2] readout_start)
    else $error("No readout after exposure");
  chk_rise_trig: assert property ($rose(exposing) && mode_r != MODE_STREAM |-> !$past(trig_n, 2))
    else $error("Exposure without trigger");
  chk_level_end: assert property (mode_r == MODE_LEVEL && $rose(trig_n) |-> ##[3:5] !exposing)
    else $error("Level exposure not ended");
  chk_busy_dark: assert property (bz_r && mode_r != MODE_STREAM |-> !exposing)
    else $error("Exposure during readout");
  chk_one_read: assert property (bz_r && mode_r != MODE_STREAM |-> !readout_start)
    else $error("Second readout while busy");
  chk_halt_dark: assert property (!arm_r && !$past(arm_r) |-> !exposing)
    else $error("Exposure while halted");
  // Main scenarios
  cover property ($rose(exposing) && mode_r == MODE_STREAM);
  cover property ($rose(exposing) && mode_r == MODE_LEVEL);
  cover property (bz_r && $fell(trig_n));
endmodule
`default_nettype wire

// File: verif/trig_source.sv
`timescale 1ns/1ps
`default_nettype none
// Trigger source: line idles high and is pulled low to request a frame
module trig_source (
  input wire logic clk,
  output logic trig_n
);
  initial trig_n = 1'h1;
  // Low for n cycles; in level mode n sets the exposure length
  task automatic pulse(input int n);
    @(posedge clk);
    trig_n <= 1'h0;
    repeat (n) @(posedge clk);
    trig_n <= 1'h1;
  endtask
endmodule
`default_nettype wire

// File: verif/ext_trigger_exposure_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"
bind ext_trigger_exposure_ctrl trig_checker trig_checker_inst (.clk(clk), .reset(reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .trig_n(trig_n),
  .readout_done(readout_done), .readout_start(readout_start), .exposing(exposing));
module ext_trigger_exposure_ctrl_test;
  import trig_pkg::*;
  logic clk, reset, hsel, hwrite, readout_done, exp_d = 1'h0;
  logic trig_n, hready, hreadyout, hresp, readout_start, exposing;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [10:0] rd_d = 11'h0;
  int n_fail = 0, checked = 0, nexp = 0, nrise = 0, nrd = 0;
  assign hready = hreadyout;
  ext_trigger_exposure_ctrl ext_trigger_exposure_ctrl_inst (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trig_n(trig_n), .readout_done(readout_done),
    .readout_start(readout_start), .exposing(exposing));
  trig_source trig_source_inst (.clk(clk), .trig_n(trig_n));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Slow readout engine and exposure counters
  always @(posedge clk) begin
    if (reset) begin
      rd_d <= 11'h0;
      readout_done <= 1'h0;
    end else begin
      rd_d <= {rd_d[9:0], readout_start};
      readout_done <= rd_d[10];
      exp_d <= exposing;
      nexp <= nexp + (exposing ? 1 : 0);
      nrise <= nrise + ((exposing && !exp_d) ? 1 : 0);
      nrd <= nrd + (readout_start ? 1 : 0);
    end
  end
  // Single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    final_report();
  end
  // Test sequence
  initial begin
    reset <= 1'h1;
    hsel <= 1'h0;
    hwrite <= 1'h0;
    htrans <= 2'h0;
    hsize <= 3'h2;
    haddr <= 32'h0;
    hwdata <= 32'h0;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    bus(1'h0, `OFS_EXPOSE, 32'h0);
    check("expose reset", q, `EXPOSE_RST);
    bus(1'h0, `OFS_INTERVAL, 32'h0);
    check("interval reset", q, `INTERVAL_RST);
    bus(1'h0, `OFS_STATUS, 32'h0);
    check("status reset", q, 32'h0);
    $display("test reset done");
    bus(1'h1, `OFS_EXPOSE, 32'h5);
    bus(1'h1, `OFS_CTRL, 32'h3);
    bus(1'h0, `OFS_CTRL, 32'h0);
    check("ctrl readback", q, 32'h3);
    bus(1'h1, `OFS_EXPOSE, 32'h9);
    trig_source_inst.pulse(8);
    while (readout_start !== 1'h1) @(posedge clk);
    trig_source_inst.pulse(4);
    repeat (40) @(posedge clk);
    check("async cycles", nexp, 5);
    check("async rises", nrise, 1);
    trig_source_inst.pulse(8);
    repeat (40) @(posedge clk);
    check("async again", nrise, 2);
    check("async latched", nexp, 10);
    $display("test async done");
    bus(1'h1, `OFS_CTRL, 32'h0);
    bus(1'h1, `OFS_CTRL, 32'h5);
    trig_source_inst.pulse(15);
    while (readout_start !== 1'h1) @(posedge clk);
    trig_source_inst.pulse(4);
    repeat (40) @(posedge clk);
    check("level cycles", nexp, 25);
    check("level rises", nrise, 3);
    $display("test level done");
    bus(1'h1, `OFS_CTRL, 32'h0);
    bus(1'h1, `OFS_EXPOSE, 32'h4);
    bus(1'h1, `OFS_INTERVAL, 32'hA);
    bus(1'h1, `OFS_CTRL, 32'h1);
    trig_source_inst.pulse(6);
    trig_source_inst.pulse(6);
    repeat (24) @(posedge clk);
    bus(1'h1, `OFS_CTRL, 32'h0);
    trig_source_inst.pulse(6);
    repeat (20) @(posedge clk);
    check("stream frames", nrise, 7);
    check("stream cycles", nexp, 41);
    check("readouts", nrd, 7);
    check("halt dark", exposing, 1'h0);
    bus(1'h0, `OFS_STATUS, 32'h0);
    check("status frames", q, 32'h0007_0000);
    check("bus ready", hreadyout, 1'h1);
    check("bus okay", hresp, 1'h0);
    $display("test stream done");
    final_report();
  end
endmodule
`default_nettype wire
